// ---- design/rtac_pkg.sv ----
package rtac_pkg;

   // ------------------------------------------------------------
   // register port geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // ------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------
   localparam logic [3:0] CTRL_LOW_ADDR   = 4'h0;
   localparam logic [3:0] CTRL_HIGH_ADDR  = 4'h1;
   localparam logic [3:0] COARSE_ADDR     = 4'h2;
   localparam logic [3:0] FINE_ADDR       = 4'h3;
   localparam logic [3:0] STATUS_ADDR     = 4'h4;
   localparam logic [3:0] ALARM_BASE_ADDR = 4'h5;
   localparam logic [3:0] TS_BASE_ADDR    = 4'h9;
   localparam int         WORDS           = 4;

   // ------------------------------------------------------------
   // control and status bit positions
   // ------------------------------------------------------------
   localparam int TS_ENABLE_BIT  = 0;
   localparam int OUT_ENABLE_BIT = 7;
   localparam int ALARM_EN_BIT   = 15;
   localparam int INDEF_BIT      = 14;
   localparam int MASK_LSB       = 8;
   localparam int REPEAT_LSB     = 0;
   localparam int EVENT_FLAG_BIT = 3;

   // ------------------------------------------------------------
   // implemented bits and reset values
   // ------------------------------------------------------------
   localparam logic [15:0] CTRL_LOW_MASK  = 16'h0081;
   localparam logic [15:0] CTRL_HIGH_MASK = 16'hcfff;
   localparam logic [15:0] FINE_MASK      = 16'h001f;
   localparam logic [15:0] FIELD_MASK [WORDS] =
      '{16'h7f00, 16'h3f7f, 16'h3f07, 16'hff1f};
   localparam logic [15:0] CTRL_LOW_RESET  = 16'h0000;
   localparam logic [15:0] CTRL_HIGH_RESET = 16'h0000;
   localparam logic [15:0] COARSE_RESET    = 16'h0400;
   localparam logic [4:0]  FINE_RESET      = 5'h00;
   localparam logic [15:0] WORD_RESET      = 16'h0000;

   // ------------------------------------------------------------
   // alarm mask codes
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      MASK_HALF   = 4'h0,
      MASK_SECOND = 4'h1,
      MASK_TEN_S  = 4'h2,
      MASK_MINUTE = 4'h3,
      MASK_TEN_M  = 4'h4,
      MASK_HOUR   = 4'h5,
      MASK_DAY    = 4'h6,
      MASK_WEEK   = 4'h7,
      MASK_MONTH  = 4'h8,
      MASK_YEAR   = 4'h9
   } rtac_mask_type;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [2:0] sec_tens;
      logic [3:0] sec_units;
      logic [2:0] minute_tens_digit;
      logic [3:0] minute_units_digit;
      logic [1:0] hour_tens_digit;
      logic [3:0] hour_units_digit;
      logic [2:0] weekday_digit;
      logic [1:0] day_tens_digit;
      logic [3:0] day_units_digit;
      logic       month_tens_digit;
      logic [3:0] month_units_digit;
      logic [3:0] year_tens_digit;
      logic [3:0] year_units_digit;
   } rtac_time_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } rtac_bus_type;

   // ------------------------------------------------------------
   // word layouts: seconds, hour/minute, day/weekday, year/month
   // ------------------------------------------------------------
   function automatic logic [15:0] time_word(rtac_time_type t,
                                             logic [1:0] idx);
      logic [15:0] w;
      w = '0;
      case (idx)
         2'd0: w = {1'b0, t.sec_tens, t.sec_units, 8'h00};
         2'd1: w = {2'b00, t.hour_tens_digit, t.hour_units_digit,
                    1'b0, t.minute_tens_digit, t.minute_units_digit};
         2'd2: w = {2'b00, t.day_tens_digit, t.day_units_digit,
                    5'h00, t.weekday_digit};
         default: w = {t.year_tens_digit, t.year_units_digit, 3'b000,
                       t.month_tens_digit, t.month_units_digit};
      endcase
      return w;
   endfunction

   function automatic rtac_time_type word_time(logic [15:0] w0,
      logic [15:0] w1, logic [15:0] w2, logic [15:0] w3);
      rtac_time_type t;
      t = '0;
      t.sec_tens           = w0[14:12];
      t.sec_units          = w0[11:8];
      t.hour_tens_digit    = w1[13:12];
      t.hour_units_digit   = w1[11:8];
      t.minute_tens_digit  = w1[6:4];
      t.minute_units_digit = w1[3:0];
      t.day_tens_digit     = w2[13:12];
      t.day_units_digit    = w2[11:8];
      t.weekday_digit      = w2[2:0];
      t.year_tens_digit    = w3[15:12];
      t.year_units_digit   = w3[11:8];
      t.month_tens_digit   = w3[4];
      t.month_units_digit  = w3[3:0];
      return t;
   endfunction

endpackage

// ---- design/rtac_prescaler.sv ----
module rtac_prescaler
   import rtac_pkg::*;
#(
   parameter int COARSE_W = 16,
   parameter int FINE_W   = 5
)
(
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                rstn,
   input  wire logic                soft_reset,
   // crystal and divider
   input  wire logic                xtal_tick,
   input  wire logic [COARSE_W-1:0] coarse_div,
   input  wire logic [FINE_W-1:0]   fine_div,
   // ticks
   output logic                     half_tick,
   output logic                     second_tick
);

   localparam int RATIO_W = COARSE_W + FINE_W;

   logic [RATIO_W-1:0] ratio;
   logic [RATIO_W-1:0] count_reg;
   logic [RATIO_W-1:0] count_next;
   logic               at_end;
   logic               at_half;

   // fine bits are the low end, so they move the period by one tick
   assign ratio      = {coarse_div, fine_div};                 // RULE6 RULE7
   assign at_end     = count_reg >= ratio;
   assign at_half    = count_reg == (ratio >> 1);
   assign count_next = at_end ? '0 : count_reg + 1'b1;

   // period is ratio+1 crystal ticks, half tick at midpoint and end
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         count_reg   <= '0;
         half_tick   <= 1'b0;
         second_tick <= 1'b0;
      end
      else if (soft_reset)
      begin
         count_reg   <= '0;
         half_tick   <= 1'b0;
         second_tick <= 1'b0;
      end
      else
      begin
         half_tick   <= xtal_tick && (at_half || at_end);      // RULE20
         second_tick <= xtal_tick && at_end;                   // RULE6
         if (xtal_tick)
            count_reg <= count_next;
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn || soft_reset);

   second_end_a: assert property (xtal_tick && at_end |=> second_tick) // RULE6
      else $error("second tick missing at end of period");
   half_mid_a: assert property (                           // RULE20
      xtal_tick && at_half && !at_end |=> half_tick && !second_tick)
      else $error("half tick missing at midpoint");

endmodule // rtac_prescaler

// ---- design/rtac_alarm_match.sv ----
module rtac_alarm_match
   import rtac_pkg::*;
(
   // compared values
   input  wire rtac_time_type alarm_time,
   input  wire rtac_time_type now_time,
   input  wire logic [3:0]    alarm_mask,
   input  wire logic          on_second,
   // result
   output logic               match
);

   logic s1, s2, m1, m2, hh, wd, dd, mo;

   // each mask step from second up to weekly adds one more digit group; monthly and yearly compare the date instead of the weekday
   always_comb
   begin
      s1 = on_second && alarm_time.sec_units == now_time.sec_units;
      s2 = s1 && alarm_time.sec_tens == now_time.sec_tens;
      m1 = s2 &&
           alarm_time.minute_units_digit == now_time.minute_units_digit;
      m2 = m1 &&
           alarm_time.minute_tens_digit == now_time.minute_tens_digit;
      hh = m2 && alarm_time.hour_tens_digit == now_time.hour_tens_digit
              && alarm_time.hour_units_digit == now_time.hour_units_digit;
      wd = alarm_time.weekday_digit == now_time.weekday_digit;
      dd = alarm_time.day_tens_digit == now_time.day_tens_digit
           && alarm_time.day_units_digit == now_time.day_units_digit;
      mo = alarm_time.month_tens_digit == now_time.month_tens_digit
           && alarm_time.month_units_digit == now_time.month_units_digit;
      // a 29 February yearly alarm only sees its date in leap years
      case (alarm_mask)                                        // RULE11
         MASK_HALF:   match = 1'b1;
         MASK_SECOND: match = on_second;
         MASK_TEN_S:  match = s1;
         MASK_MINUTE: match = s2;
         MASK_TEN_M:  match = m1;
         MASK_HOUR:   match = m2;
         MASK_DAY:    match = hh;
         MASK_WEEK:   match = hh && wd;
         MASK_MONTH:  match = hh && dd;
         MASK_YEAR:   match = hh && dd && mo;                  // RULE12
         default:     match = 1'b0;
      endcase
   end

endmodule // rtac_alarm_match

// ---- design/rtac_core.sv ----
// How it works
// [RULE1] timestamp hour/minute word: hour tens 13:12, units 11:8, minutes 6:0
// [RULE2] timestamp day word: day tens 13:12, units 11:8, weekday 2:0
// [RULE3] timestamp year/month word: year 15:8, month tens bit 4, units 3:0
// [RULE4] unimplemented timestamp bits read zero, ignore writes; power-on zero
// [RULE5] with capture off all 16 bits store data, surviving soft reset
// [RULE6] 16-bit coarse and 5-bit fine divider form one 21-bit ratio
// [RULE7] larger fine value slows ticks slightly, larger coarse value more
// [RULE8] alarm acts only while alarm enable bit 15 is set
// [RULE9] software writes alarm values only with alarm disabled
// [RULE10] mask field 11:8 picks which digits must equal the clock
// [RULE11] mask codes run from every half second up to yearly
// [RULE12] yearly alarm on 29 February fires only in leap years
// [RULE13] repeat count 7:0 gives extra alarms; zero means single alarm
// [RULE14] each alarm decrements count; at zero without repeat, enable clears
// [RULE15] indefinite repeat bit 14 wraps count to ff and keeps alarming
// [RULE16] every alarm raises an interrupt synchronous to this clock
// [RULE17] software changes only output enable, count, repeat while enabled
// [RULE18] tamper low pulse with capture on copies time, sets flag, interrupts
// [RULE19] further captures ignored until software clears the event flag
// [RULE20] half-second tick from prescaler drives alarm evaluation
//
// Chosen here: the address map and strobed register access.
module rtac_core
   import rtac_pkg::*;
(
   // clock and resets
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              soft_reset,
   // register port
   input  wire rtac_bus_type      bus,
   output logic [DATA_W-1:0]      rd_data,
   // time base and live calendar
   input  wire logic              xtal_tick,
   input  wire rtac_time_type     now_time,
   input  wire logic              tamper_input_n,
   // outputs
   output logic                   second_tick,
   output logic                   alarm_irq,
   output logic                   clock_irq,
   output logic                   clock_output_enable
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [15:0]  ctrl_low_reg;
   logic [15:0]  ctrl_high_reg;
   logic [15:0]  coarse_reg;
   logic [4:0]   fine_reg;
   logic [15:0]  alarm_reg [WORDS];
   logic [15:0]  ts_reg [WORDS];
   logic         event_flag_reg;
   logic         tamper_prev_reg;
   logic         alarm_irq_reg;
   logic         clock_irq_reg;
   logic [15:0]  rd_data_reg;
   logic [15:0]  rd_data_next;

   logic         half_tick;
   logic         match;
   logic         ts_enable;
   logic         alarm_en;
   logic         indef;
   logic [7:0]   repeat_count;
   logic [3:0]   mask;
   logic         wr_high;
   logic         wr_status;
   logic         manual_req;
   logic         tamper_fall;
   logic         capture_go;
   logic         alarm_fire;
   logic [15:0]  now_word [WORDS];
   logic [WORDS-1:0] wr_alarm;
   logic [WORDS-1:0] wr_ts;
   rtac_time_type alarm_time;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   assign ts_enable    = ctrl_low_reg[TS_ENABLE_BIT];
   assign alarm_en     = ctrl_high_reg[ALARM_EN_BIT];
   assign indef        = ctrl_high_reg[INDEF_BIT];
   assign repeat_count = ctrl_high_reg[REPEAT_LSB +: 8];       // RULE13
   assign mask         = ctrl_high_reg[MASK_LSB +: 4];         // RULE10
   assign wr_high      = bus.wr && bus.addr == CTRL_HIGH_ADDR;
   assign wr_status    = bus.wr && bus.addr == STATUS_ADDR;
   assign manual_req   = wr_status && bus.wdata[EVENT_FLAG_BIT];
   assign tamper_fall  = tamper_prev_reg && !tamper_input_n;
   // a held flag blocks both tamper and manual capture
   assign capture_go   = ts_enable && !event_flag_reg &&       // RULE19
                         (tamper_fall || manual_req);          // RULE18
   assign alarm_fire   = alarm_en && half_tick && match;       // RULE8
   assign alarm_time   = word_time(alarm_reg[0], alarm_reg[1],
                                   alarm_reg[2], alarm_reg[3]);

   // ------------------------------------------------------------
   // time base and comparison
   // ------------------------------------------------------------
   rtac_prescaler #(
      .COARSE_W (16),
      .FINE_W   (5)
   ) u_prescaler (
      .mclk        (mclk),
      .rstn        (rstn),
      .soft_reset  (soft_reset),
      .xtal_tick   (xtal_tick),
      .coarse_div  (coarse_reg),
      .fine_div    (fine_reg),
      .half_tick   (half_tick),
      .second_tick (second_tick)
   );

   rtac_alarm_match u_match (
      .alarm_time (alarm_time),
      .now_time   (now_time),
      .alarm_mask (mask),
      .on_second  (second_tick),
      .match      (match)
   );

   // ------------------------------------------------------------
   // alarm and timestamp words, one entry per generate step
   // ------------------------------------------------------------
   for (genvar i = 0; i < WORDS; i++)
   begin : g_word
      assign now_word[i] = time_word(now_time, 2'(i));         // RULE1 RULE2 RULE3
      assign wr_alarm[i] = bus.wr &&
                           bus.addr == ALARM_BASE_ADDR + 4'(i);
      assign wr_ts[i]    = bus.wr && bus.addr == TS_BASE_ADDR + 4'(i);

      // alarm values: only digit fields exist
      always_ff @(posedge mclk or negedge rstn)
      begin
         if (!rstn)
            alarm_reg[i] <= WORD_RESET;
         else if (soft_reset)
            alarm_reg[i] <= WORD_RESET;
         else if (wr_alarm[i])
            alarm_reg[i] <= bus.wdata & FIELD_MASK[i];
      end

      // timestamp words clear only at power-on, so they can hold data
      // across a soft reset; capture wins over a write in the same cycle
      always_ff @(posedge mclk or negedge rstn)
      begin
         if (!rstn)
            ts_reg[i] <= WORD_RESET;                           // RULE4
         else if (capture_go)
            ts_reg[i] <= now_word[i];                          // RULE18
         else if (wr_ts[i] && !soft_reset)
         begin
            if (ts_enable)
               ts_reg[i] <= bus.wdata & FIELD_MASK[i];         // RULE4
            else
               ts_reg[i] <= bus.wdata;                         // RULE5
         end
      end
   end

   // ------------------------------------------------------------
   // control registers
   // ------------------------------------------------------------
   // low control, coarse and fine divider
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_low_reg <= CTRL_LOW_RESET;
         coarse_reg   <= COARSE_RESET;
         fine_reg     <= FINE_RESET;
      end
      else if (soft_reset)
      begin
         ctrl_low_reg <= CTRL_LOW_RESET;
         coarse_reg   <= COARSE_RESET;
         fine_reg     <= FINE_RESET;
      end
      else if (bus.wr)
      begin
         if (bus.addr == CTRL_LOW_ADDR)
            ctrl_low_reg <= bus.wdata & CTRL_LOW_MASK;
         if (bus.addr == COARSE_ADDR)
            coarse_reg <= bus.wdata;                           // RULE6
         if (bus.addr == FINE_ADDR)
            fine_reg <= bus.wdata[4:0];                        // RULE6
      end
   end

   // high control; a software write in the firing cycle wins, since
   // software owns the alarm settings
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ctrl_high_reg <= CTRL_HIGH_RESET;
      else if (soft_reset)
         ctrl_high_reg <= CTRL_HIGH_RESET;
      else if (wr_high)
         ctrl_high_reg <= bus.wdata & CTRL_HIGH_MASK;
      else if (alarm_fire)
      begin
         if (repeat_count == 8'h00 && !indef)
            ctrl_high_reg[ALARM_EN_BIT] <= 1'b0;               // RULE14
         else
            ctrl_high_reg[REPEAT_LSB +: 8] <= repeat_count - 8'h01; // RULE14 RULE15
      end
   end

   // ------------------------------------------------------------
   // timestamp event flag and tamper edge
   // ------------------------------------------------------------
   // writing 0 to the flag clears it; a capture can only start while
   // the flag is clear, and it wins over a clearing write in the same cycle
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         event_flag_reg  <= 1'b0;
         tamper_prev_reg <= 1'b1;
      end
      else if (soft_reset)
      begin
         event_flag_reg  <= 1'b0;
         tamper_prev_reg <= 1'b1;
      end
      else
      begin
         tamper_prev_reg <= tamper_input_n;
         if (capture_go)
            event_flag_reg <= 1'b1;                            // RULE18
         else if (wr_status && !bus.wdata[EVENT_FLAG_BIT])
            event_flag_reg <= 1'b0;                            // RULE19
      end
   end

   // ------------------------------------------------------------
   // interrupts and read data
   // ------------------------------------------------------------
   // one-cycle pulses, both on this clock
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         alarm_irq_reg <= 1'b0;
         clock_irq_reg <= 1'b0;
      end
      else if (soft_reset)
      begin
         alarm_irq_reg <= 1'b0;
         clock_irq_reg <= 1'b0;
      end
      else
      begin
         alarm_irq_reg <= alarm_fire;                          // RULE16
         clock_irq_reg <= alarm_fire || capture_go;            // RULE18
      end
   end

   // read mux; unmapped indices read zero
   always_comb
   begin
      rd_data_next = '0;
      if (bus.addr == CTRL_LOW_ADDR)
         rd_data_next = ctrl_low_reg;
      else if (bus.addr == CTRL_HIGH_ADDR)
         rd_data_next = ctrl_high_reg;
      else if (bus.addr == COARSE_ADDR)
         rd_data_next = coarse_reg;
      else if (bus.addr == FINE_ADDR)
         rd_data_next = {11'h000, fine_reg};
      else if (bus.addr == STATUS_ADDR)
         rd_data_next = 16'(event_flag_reg) << EVENT_FLAG_BIT;
      else
         for (int k = 0; k < WORDS; k++)
         begin
            if (bus.addr == ALARM_BASE_ADDR + 4'(k))
               rd_data_next = alarm_reg[k];
            if (bus.addr == TS_BASE_ADDR + 4'(k))
               rd_data_next = ts_enable ?                      // RULE4
                  ts_reg[k] & FIELD_MASK[k] : ts_reg[k];       // RULE5
         end
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rd_data_reg <= '0;
      else
         rd_data_reg <= bus.rd ? rd_data_next : '0;
   end

   assign rd_data             = rd_data_reg;
   assign alarm_irq           = alarm_irq_reg;
   assign clock_irq           = clock_irq_reg;
   assign clock_output_enable = ctrl_low_reg[OUT_ENABLE_BIT];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn || soft_reset);

   sequence fire_s;
      alarm_fire && !wr_high;
   endsequence

   ts_capture_a: assert property (capture_go |=>                // RULE18
      ts_reg[1] == $past(now_word[1]) && event_flag_reg && clock_irq)
      else $error("capture did not copy time or raise flag");
   ts_hold_a: assert property (event_flag_reg && !wr_ts[2]      // RULE19
      && !(wr_status && !bus.wdata[EVENT_FLAG_BIT]) |=> $stable(ts_reg[2]))
      else $error("timestamp changed while flag held");
   ts_zero_a: assert property (ts_enable && bus.rd &&           // RULE4
      bus.addr == TS_BASE_ADDR + 4'h1 |=> (rd_data & ~FIELD_MASK[1]) == '0)
      else $error("unimplemented timestamp bits read nonzero");
   ts_keep_a: assert property (@(posedge mclk) disable iff (!rstn) // RULE5
      soft_reset && !capture_go |=> $stable(ts_reg[3]))
      else $error("timestamp lost across soft reset");
   alarm_gate_a: assert property (!alarm_en |=> !alarm_irq)     // RULE8
      else $error("alarm interrupt while disabled");
   alarm_dec_a: assert property (fire_s ##0 repeat_count != 8'h00 // RULE14
      |=> repeat_count == $past(repeat_count) - 8'h01 && alarm_irq)
      else $error("repeat count not decremented");
   alarm_off_a: assert property (fire_s ##0 repeat_count == 8'h00 // RULE14
      && !indef |=> !alarm_en && alarm_irq)
      else $error("alarm not disabled after last repeat");
   alarm_wrap_a: assert property (fire_s ##0 repeat_count == 8'h00 // RULE15
      && indef |=> alarm_en && repeat_count == 8'hff)
      else $error("indefinite repeat did not wrap");
   alarm_irq_a: assert property (alarm_fire |=> alarm_irq && clock_irq) // RULE16
      else $error("alarm without interrupt");
   mask_sec_a: assert property (alarm_en && half_tick && !second_tick // RULE11
      && mask != MASK_HALF |=> !alarm_irq)
      else $error("alarm off the second boundary");

endmodule // rtac_core

// ---- tb/rtc_alarm_timestamp_calibration_tb.sv ----
module rtc_alarm_timestamp_calibration_tb
   import rtac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic          mclk, rstn, soft_reset, xtal_tick, tamper_input_n;
   rtac_bus_type  bus;
   rtac_time_type now_time, t0;
   logic [15:0]   rd_data, d, r;
   logic [15:0]   w [4];
   logic          second_tick, alarm_irq, clock_irq, clock_output_enable;
   int            errors, compares, nal, ncl, nboth, cyc, n, a0;
   rtac_core i_dut (.mclk(mclk), .rstn(rstn), .soft_reset(soft_reset),
      .bus(bus), .rd_data(rd_data), .xtal_tick(xtal_tick),
      .now_time(now_time), .tamper_input_n(tamper_input_n),
      .second_tick(second_tick), .alarm_irq(alarm_irq),
      .clock_irq(clock_irq), .clock_output_enable(clock_output_enable));
   // 100 mhz clock
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // pulse counters and hang guard
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      nal <= nal + int'(alarm_irq === 1'b1);
      ncl <= ncl + int'(clock_irq === 1'b1);
      nboth <= nboth + int'(alarm_irq === 1'b1 && clock_irq === 1'b1);
      if (cyc == 20000)
      begin
         errors++;
         report_and_stop();
      end
   end
   task report_and_stop();
      if (errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   // one bus cycle, then one idle edge so strobes never collide
   task bx(input logic [3:0] a, input logic [15:0] v, input logic wr);
      @(posedge mclk);
      bus <= '{a, v, wr, ~wr};
      @(posedge mclk);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      #1 d = rd_data;
   endtask
   task rc(input logic [3:0] a, input logic [15:0] e);
      bx(a, 16'h0000, 1'b0);
      chk(d, e);
   endtask
   task tamper();
      @(posedge mclk);
      tamper_input_n <= 1'b0;
      @(posedge mclk);
      tamper_input_n <= 1'b1;
   endtask
   function automatic logic [15:0] lf(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] ew(rtac_time_type t, int i);
      case (i)
         1: return {2'b00, t.hour_tens_digit, t.hour_units_digit, 1'b0,
                    t.minute_tens_digit, t.minute_units_digit};
         2: return {2'b00, t.day_tens_digit, t.day_units_digit, 5'h00,
                    t.weekday_digit};
         3: return {t.year_tens_digit, t.year_units_digit, 3'b000,
                    t.month_tens_digit, t.month_units_digit};
         default: return {1'b0, t.sec_tens, t.sec_units, 8'h00};
      endcase
   endfunction
   // main sequence; crystal held off until the ratio is small
   initial
   begin
      {rstn, soft_reset, xtal_tick, bus, now_time} = '0;
      {errors, compares, nal, ncl, nboth, cyc} = '0;
      tamper_input_n = 1'b1;
      r = 16'd34520;
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      rc(COARSE_ADDR, 16'h0400);
      for (int i = 0; i < 4; i++) rc(TS_BASE_ADDR + 4'(i), 16'h0000);
      rc(4'hd, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         r = lf(r);
         w[i] = r;
         bx(TS_BASE_ADDR + 4'(i), r, 1'b1);
      end
      @(posedge mclk) soft_reset <= 1'b1;
      @(posedge mclk) soft_reset <= 1'b0;
      for (int i = 0; i < 4; i++) rc(TS_BASE_ADDR + 4'(i), w[i]);
      bx(CTRL_LOW_ADDR, 16'hffff, 1'b1);
      rc(CTRL_LOW_ADDR, 16'h0081);
      chk({15'h0, clock_output_enable}, 16'h0001);
      now_time <= {r, lf(r), r[9:0]};
      t0 = {r, lf(r), r[9:0]};
      tamper();
      repeat (3) @(posedge mclk);
      now_time <= ~t0;
      tamper(); // later pulse is ignored while the flag stands
      for (int i = 0; i < 4; i++) rc(TS_BASE_ADDR + 4'(i), ew(t0, i));
      rc(STATUS_ADDR, 16'h0008);
      chk(16'(ncl), 16'h0001);
      bx(STATUS_ADDR, 16'h0000, 1'b1);
      // manual capture request through the status word
      bx(STATUS_ADDR, 16'h0008, 1'b1);
      rc(TS_BASE_ADDR + 4'h1, ew(~t0, 1));
      rc(STATUS_ADDR, 16'h0008);
      bx(STATUS_ADDR, 16'h0000, 1'b1);
      // alarm values are touched only while the alarm is off
      for (int i = 0; i < 4; i++)
      begin
         r = lf(r);
         bx(ALARM_BASE_ADDR + 4'(i), r, 1'b1);
         rc(ALARM_BASE_ADDR + 4'(i), r & FIELD_MASK[i]);
         bx(ALARM_BASE_ADDR + 4'(i), 16'h0000, 1'b1);
      end
      now_time <= '0;
      bx(FINE_ADDR, 16'h0003, 1'b1);
      bx(COARSE_ADDR, 16'h0000, 1'b1);
      xtal_tick <= 1'b1;
      for (int m = 0; m < 16; m++)
      begin
         a0 = nal;
         bx(CTRL_HIGH_ADDR, {4'h8, 4'(m), 8'h00}, 1'b1);
         repeat (20) @(posedge mclk);
         chk(16'(nal - a0), 16'(m < 10));
         rc(CTRL_HIGH_ADDR, {(m < 10) ? 4'h0 : 4'h8, 4'(m), 8'h00});
         bx(CTRL_HIGH_ADDR, 16'h0, 1'b1);
      end
      a0 = nal;
      bx(CTRL_HIGH_ADDR, 16'h8002, 1'b1);
      repeat (30) @(posedge mclk);
      chk(16'(nal - a0), 16'h0003);
      bx(CTRL_HIGH_ADDR, 16'hc000, 1'b1);
      repeat (40) @(posedge mclk);
      bx(CTRL_HIGH_ADDR, 16'h0000, 1'b0);
      chk(d & 16'hc000, 16'hc000);
      bx(CTRL_HIGH_ADDR, 16'h0000, 1'b1);
      // a pulse fired beside the disabling write is counted first
      repeat (2) @(posedge mclk);
      a0 = nal;
      repeat (20) @(posedge mclk);
      chk(16'(nal - a0), 16'h0000);
      chk(16'(nboth), 16'(nal));
      // step ratios grow 3, 9, 35; the brief drop to 3 at the last fine write just ends a period early
      for (int k = 0; k < 3; k++)
      begin
         bx(FINE_ADDR, (k == 1) ? 16'h0009 : 16'h0003, 1'b1);
         bx(COARSE_ADDR, 16'(k == 2), 1'b1);
         do @(posedge mclk); while (second_tick !== 1'b1);
         n = 0;
         do begin @(posedge mclk); n++; end while (second_tick !== 1'b1);
         chk(16'(n), (k == 0) ? 16'd4 : (k == 1) ? 16'd10 : 16'd36);
      end
      report_and_stop();
   end
endmodule // rtc_alarm_timestamp_calibration_tb
